// >>> common/ffo_consts.svh
// constants for the fifo flag and offset programming block
`ifndef FFO_CONSTS_SVH
`define FFO_CONSTS_SVH
`define FFO_DEPTH 8192
`define FFO_WIDTH 18
`define FFO_DEF_SER_OFF 16'h03FF
`define FFO_DEF_PAR_OFF 16'h007F
`define FFO_PF_SETTLE 2'h2
`define FFO_BUF_ENTRIES 2'h2
`endif

// >>> common/ffo_pkg.sv
// types shared by the fifo flag and offset programming block
package ffo_pkg;
    // which offset register a parallel pointer addresses
    typedef enum logic {FFO_SEL_EMPTY, FFO_SEL_FULL} ffo_sel_e;
endpackage

// >>> core/ffo_top.sv
// deep fifo with status flags and programmable partial-flag offsets
`timescale 1ns/1ns
`default_nettype none
`include "ffo_consts.svh"

// Notes on behaviour
// - standard timing flag thresholds on word count
// - fall-through timing flag thresholds, one extra word
// - empty offset default 127 parallel, 1023 serial
// - full offset default 127 parallel, 1023 serial
// - parallel offset write, empty then full
// - parallel offset readback, empty then full
// - loading method fixed at master reset only
// - readback always allowed, decode same both timings
// - serial shift one bit per clock, lsb first
// - serial load commits both offsets together only
// - load low, serial enable high: no shift
// - memory writes allowed between serial bits
// - serial shifting resumes at stored bit position
// - partial flags invalid, full valid two edges later
// - almost empty valid two edges after last bit
// - no serial readback of offsets
// - load select at master reset picks method
// - fall-through select at master reset picks timing
// - separate write and read offset pointers
module ffo_top
    import ffo_pkg::*;
#(
    parameter int DEPTH = `FFO_DEPTH,
    parameter int WIDTH = `FFO_WIDTH
) (
    input wire logic sys_clk, // system clock, 25 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic master_reset_n, // master reset, active low
    input wire logic load_select, // low: offset access, high: memory
    input wire logic fall_through_select, // timing select, sampled at reset
    input wire logic write_enable_n, // write enable, active low
    input wire logic read_enable_n, // read enable, active low
    input wire logic serial_enable_n, // serial shift enable, active low
    input wire logic serial_in, // serial offset bit
    input wire logic [WIDTH-1:0] data_in, // write data
    input wire logic q_ready, // receiver takes head word
    output logic [WIDTH-1:0] q_data, // head word of output buffer
    output logic q_valid, // head word present
    output logic q_is_offset, // head word is an offset readback
    output logic empty_flag_n, // standard: low when empty
    output logic output_ready_n, // fall-through: low when word ready
    output logic full_flag_n, // standard: low when full
    output logic input_ready_n, // fall-through: high when full
    output logic half_full_n, // low when more than half full
    output logic almost_full_n, // low at or above full offset
    output logic almost_empty_n, // low at or below empty offset
    output logic serial_mode, // serial loading selected
    output logic fall_through_mode // fall-through timing selected
);
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int AW = $clog2(DEPTH); // offset and pointer width
    localparam int LW = AW + 2; // level width, holds depth plus one
    localparam int SW = 2 * AW; // serial bits for both offsets
    localparam logic [LW-1:0] D_L = LW'(DEPTH);
    localparam logic [LW-1:0] ONE_L = LW'(1);
    localparam logic [LW-1:0] TWO_L = LW'(2);

    // picks the offset addressed by a parallel pointer
    function automatic logic [AW-1:0] pick_off(input ffo_sel_e sel,
            input logic [AW-1:0] e_off, input logic [AW-1:0] f_off);
        pick_off = (sel == FFO_SEL_EMPTY) ? e_off : f_off;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [WIDTH-1:0] mem [DEPTH]; // fifo storage
    logic [AW-1:0] wr_ptr_reg; // memory write pointer
    logic [AW-1:0] rd_ptr_reg; // memory read pointer
    logic [LW-1:0] mem_cnt_reg; // words held in memory
    logic [LW-1:0] level_reg; // words not yet delivered
    logic ser_reg; // latched loading method
    logic fall_through_select_reg; // latched timing mode
    logic [AW-1:0] e_off_reg; // empty offset n
    logic [AW-1:0] f_off_reg; // full offset m
    ffo_sel_e wsel_reg; // parallel write pointer
    ffo_sel_e rsel_reg; // parallel read pointer
    logic [SW-1:0] shift_reg; // serial staging bits
    logic [$clog2(SW)-1:0] pos_reg; // next serial bit position
    logic [1:0] settle_reg; // edges left until partial flags valid
    logic [WIDTH:0] buf_reg [2]; // output buffer {offset tag, word}
    logic [1:0] buf_cnt_reg; // entries in output buffer

    // ----------------------------------------
    // control decode
    // ----------------------------------------
    wire mrst = rst || !master_reset_n; // either reset acts as master reset; memory is not cleared
    wire buf_room = buf_cnt_reg != `FFO_BUF_ENTRIES;
    wire [LW-1:0] cap = fall_through_select_reg ? D_L + ONE_L : D_L; // output reg adds one
    wire wfull = (level_reg == cap) || (mem_cnt_reg == D_L);
    // parallel offset write, only in parallel method
    wire pwr = !load_select && !write_enable_n && read_enable_n
        && serial_enable_n && !ser_reg;
    // parallel readback, allowed in either method
    wire prd = !load_select && write_enable_n && !read_enable_n
        && serial_enable_n && buf_room;
    // serial shift needs both low; load low alone shifts nothing
    wire shift = !load_select && !serial_enable_n && ser_reg;
    wire last_bit = shift && (pos_reg == ($clog2(SW))'(SW - 1));
    // memory write with load high, independent of serial position
    wire mwr = load_select && !write_enable_n && !wfull;
    // fall-through pulls the head word without a read enable
    wire mrd = (mem_cnt_reg != '0) && buf_room && !prd
        && (fall_through_select_reg || (load_select && !read_enable_n));
    wire pop = q_valid && q_ready; // receiver takes head
    wire pop_data = pop && !buf_reg[0][WIDTH];
    wire [WIDTH:0] push_word = prd
        ? {1'b1, (WIDTH)'(pick_off(rsel_reg, e_off_reg, f_off_reg))}
        : {1'b0, mem[rd_ptr_reg]};
    wire push = prd || mrd;
    wire [1:0] cnt_ap = buf_cnt_reg - {1'b0, pop};
    wire [1:0] buf_cnt_next = cnt_ap + {1'b0, push};
    wire [SW-1:0] shift_next = shift_reg | (SW'(serial_in) << pos_reg);
    wire [LW-1:0] level_next = mrst ? '0
        : level_reg + LW'(mwr) - LW'(pop_data);

    // ----------------------------------------
    // next values for mode and offsets
    // ----------------------------------------
    wire ser_next = mrst ? load_select : ser_reg;
    wire fall_through_select_next = mrst ? fall_through_select : fall_through_select_reg;
    wire [AW-1:0] def_off = load_select ? AW'(`FFO_DEF_SER_OFF)
        : AW'(`FFO_DEF_PAR_OFF);
    // serial load commits both offsets only on the last bit
    wire [AW-1:0] e_off_next = mrst ? def_off
        : last_bit ? shift_next[AW-1:0]
        : (pwr && wsel_reg == FFO_SEL_EMPTY) ? data_in[AW-1:0]
        : e_off_reg;
    wire [AW-1:0] f_off_next = mrst ? def_off
        : last_bit ? shift_next[SW-1:AW]
        : (pwr && wsel_reg == FFO_SEL_FULL) ? data_in[AW-1:0]
        : f_off_reg;
    wire [1:0] settle_next = mrst ? 2'h0
        : last_bit ? `FFO_PF_SETTLE
        : (settle_reg != 2'h0) ? settle_reg - 2'h1 : 2'h0;
    // invalid from the first shifted bit until settle runs out
    // held clear in reset so the partial flags come out of reset valid
    wire pf_invalid = !mrst
        && ((pos_reg != '0) || shift || (settle_next != 2'h0));

    // ----------------------------------------
    // flag thresholds
    // ----------------------------------------
    wire [LW-1:0] n_l = LW'(e_off_next);
    wire [LW-1:0] m_l = LW'(f_off_next);
    wire [LW-1:0] hf_th = fall_through_select_next ? (D_L >> 1) + TWO_L : (D_L >> 1) + ONE_L;
    wire [LW-1:0] af_th = fall_through_select_next ? D_L + ONE_L - m_l : D_L - m_l;
    wire [LW-1:0] ae_th = fall_through_select_next ? n_l + ONE_L : n_l;
    wire ef_next = !fall_through_select_next ? (level_next != '0) : 1'b1;
    wire ff_next = !fall_through_select_next ? (level_next != D_L) : 1'b1;
    wire or_next = fall_through_select_next ? (level_next < ONE_L) : 1'b1;
    wire ir_next = fall_through_select_next ? (level_next == D_L + ONE_L) : 1'b1;
    wire hf_next = !(level_next >= hf_th);
    wire af_next = pf_invalid || !(level_next >= af_th);
    wire ae_next = pf_invalid || (level_next > ae_th);

    // ----------------------------------------
    // memory array, no reset needed
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (mwr) begin
            mem[wr_ptr_reg] <= data_in;
        end
    end

    // ----------------------------------------
    // pointers, counts and mode latches
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        ser_reg <= ser_next;
        fall_through_select_reg <= fall_through_select_next;
        level_reg <= level_next;
        if (mrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            mem_cnt_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + AW'(mwr);
            rd_ptr_reg <= rd_ptr_reg + AW'(mrd);
            mem_cnt_reg <= mem_cnt_reg + LW'(mwr) - LW'(mrd);
        end
    end

    // ----------------------------------------
    // offsets and parallel pointers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        e_off_reg <= e_off_next;
        f_off_reg <= f_off_next;
        settle_reg <= settle_next;
        if (mrst) begin
            wsel_reg <= FFO_SEL_EMPTY;
            rsel_reg <= FFO_SEL_EMPTY;
        end else begin
            // each access steps its own pointer to the other register
            if (pwr) begin
                wsel_reg <= (wsel_reg == FFO_SEL_EMPTY) ? FFO_SEL_FULL : FFO_SEL_EMPTY;
            end
            if (prd) begin
                rsel_reg <= (rsel_reg == FFO_SEL_EMPTY) ? FFO_SEL_FULL : FFO_SEL_EMPTY;
            end
        end
    end

    // ----------------------------------------
    // serial shift position
    // ----------------------------------------
    // position is held while paused, so loading picks up where it left
    always_ff @(posedge sys_clk) begin
        if (mrst || last_bit) begin
            pos_reg <= '0;
            shift_reg <= '0;
        end else if (shift) begin
            pos_reg <= pos_reg + 1'b1;
            shift_reg <= shift_next;
        end
    end

    // ----------------------------------------
    // two-entry output buffer
    // ----------------------------------------
    // a stalled receiver stops memory reads, never drops a word
    always_ff @(posedge sys_clk) begin
        if (mrst) begin
            buf_cnt_reg <= 2'h0;
            q_valid <= 1'b0;
            buf_reg[0] <= '0;
            buf_reg[1] <= '0;
        end else begin
            buf_cnt_reg <= buf_cnt_next;
            q_valid <= buf_cnt_next != 2'h0; // registered twin of the entry count
            if (pop) begin
                buf_reg[0] <= buf_reg[1];
            end
            if (push && cnt_ap == 2'h0) begin
                buf_reg[0] <= push_word;
            end else if (push) begin
                buf_reg[1] <= push_word;
            end
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        empty_flag_n <= ef_next;
        full_flag_n <= ff_next;
        output_ready_n <= or_next;
        input_ready_n <= ir_next;
        half_full_n <= hf_next;
        almost_full_n <= af_next;
        almost_empty_n <= ae_next;
        serial_mode <= ser_next;
        fall_through_mode <= fall_through_select_next;
    end
    assign q_data = buf_reg[0][WIDTH-1:0];
    assign q_is_offset = buf_reg[0][WIDTH];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (mrst);

    sequence s_last_shift;
        last_bit;
    endsequence
    // almost empty follows the new empty offset once settled
    sequence s_settled;
        almost_empty_n == (level_reg > (fall_through_select_reg ? LW'(e_off_reg) + ONE_L : LW'(e_off_reg)));
    endsequence

    a_std_empty_flag: assert property (!fall_through_select_reg
        |-> ##1 (empty_flag_n == ($past(level_next) != '0)))
        else $error("empty flag does not follow word count");
    a_std_full_flag: assert property (!fall_through_select_reg && level_next == D_L |=> !full_flag_n)
        else $error("full flag not low at depth");
    a_ft_input_ready: assert property (fall_through_select_reg && level_next == D_L + ONE_L
        |=> input_ready_n)
        else $error("input ready not high at depth plus one");
    a_ft_out_ready: assert property (fall_through_select_reg && level_next == ONE_L |=> !output_ready_n)
        else $error("output ready not low with one word");
    a_pf_settle: assert property (s_last_shift |=> almost_full_n ##1 almost_full_n)
        else $error("partial flag valid too early");
    a_pf_valid: assert property (s_last_shift ##1 !shift [*2]
        |=> settle_reg == 2'h0 ##0 s_settled)
        else $error("partial flags not valid two edges after load");
    a_pause_hold: assert property (!load_select && serial_enable_n |=> $stable(pos_reg))
        else $error("serial position moved while paused");
    a_method_fixed: assert property (##1 $stable(ser_reg))
        else $error("loading method changed outside master reset");
    a_par_ptr_step: assert property (pwr |=> wsel_reg != $past(wsel_reg))
        else $error("write offset pointer did not step");
    a_ser_commit: assert property (shift && !last_bit
        |=> $stable(e_off_reg) && $stable(f_off_reg))
        else $error("offset changed before full serial set");
    a_no_ser_par: assert property (ser_reg && !last_bit
        |=> $stable(e_off_reg) && $stable(f_off_reg))
        else $error("offset changed by parallel write in serial method");
endmodule
`default_nettype wire

// >>> verif/ffo_sink.sv
// far-side reader model that takes head words from the output buffer
`timescale 1ns/1ns
`default_nettype none
module ffo_sink #(
    parameter int WIDTH = 18 // word width
) (
    input wire logic sys_clk, // system clock
    input wire logic stall, // bench holds the reader off
    input wire logic q_valid, // head word present
    input wire logic [WIDTH-1:0] q_data, // head word
    input wire logic q_is_offset, // head word is an offset readback
    output logic q_ready // reader takes head word
);
    logic [WIDTH-1:0] got[$]; // words taken, oldest first
    logic tag[$]; // offset marks of the words taken
    // ----------------------------------------
    // reader
    // ----------------------------------------
    // ready drops while stalled, so the buffer must keep every word
    assign q_ready = !stall;
    always @(posedge sys_clk) begin
        if (q_valid === 1'b1 && q_ready) begin
            got.push_back(q_data);
            tag.push_back(q_is_offset);
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb_ffo_top.sv
// self-checking testbench for the fifo flag and offset block
`timescale 1ns/1ns
`default_nettype none
`include "ffo_consts.svh"
module tb_ffo_top;
    localparam int D = 1024; // shortened depth, offsets are 10 bits
    localparam int SB = 2 * $clog2(D); // serial bits for both offsets
    localparam logic [17:0] DP = 18'(`FFO_DEF_PAR_OFF) & 18'(D - 1); // parallel default
    localparam logic [17:0] DS = 18'(`FFO_DEF_SER_OFF) & 18'(D - 1); // serial default
    logic sys_clk = 1'b0, rst = 1'b1, mrst_n = 1'b1, ld = 1'b0, fts = 1'b0; // clock and mode pins
    logic wen_n = 1'b1, ren_n = 1'b1, sen_n = 1'b1, si = 1'b0, stall = 1'b0; // strobes
    logic [17:0] din = 18'h00000; // write data
    logic [17:0] q_data; // head word
    logic q_valid, q_ready, q_is_off, ef_n, or_n, ff_n, ir_n, hf_n, af_n, ae_n, ser_m, ft_m;
    int mismatches = 0, comparisons = 0; // verdict counters
    always #20 sys_clk = ~sys_clk;
    ffo_top #(.DEPTH(D)) i_ffo_top (.sys_clk(sys_clk), .rst(rst), .master_reset_n(mrst_n),
        .load_select(ld), .fall_through_select(fts), .write_enable_n(wen_n),
        .read_enable_n(ren_n), .serial_enable_n(sen_n), .serial_in(si), .data_in(din),
        .q_ready(q_ready), .q_data(q_data), .q_valid(q_valid), .q_is_offset(q_is_off),
        .empty_flag_n(ef_n), .output_ready_n(or_n), .full_flag_n(ff_n), .input_ready_n(ir_n),
        .half_full_n(hf_n), .almost_full_n(af_n), .almost_empty_n(ae_n),
        .serial_mode(ser_m), .fall_through_mode(ft_m));
    ffo_sink i_ffo_sink (.sys_clk(sys_clk), .stall(stall), .q_valid(q_valid),
        .q_data(q_data), .q_is_offset(q_is_off), .q_ready(q_ready));
    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic end_sim();
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    // flag levels expected for a word count c in either timing
    task automatic flags(input int c, input bit ft, input int n, input int m);
        if (!ft) begin
            chk("empty", ef_n, c != 0);
            chk("full", ff_n, c != D);
            chk("half", hf_n, c < D / 2 + 1);
            chk("afull", af_n, c < D - m);
            chk("aempty", ae_n, c > n);
        end else begin
            chk("oready", or_n, c < 1);
            chk("iready", ir_n, c == D + 1);
            chk("half", hf_n, c < D / 2 + 2);
            chk("afull", af_n, c < D + 1 - m);
            chk("aempty", ae_n, c > n + 1);
        end
    endtask
    // two parallel offset reads, popped by the reader model
    task automatic rd_off(input logic [17:0] e, input logic [17:0] f);
        i_ffo_sink.got.delete();
        i_ffo_sink.tag.delete();
        ld = 1'b0;
        ren_n = 1'b0;
        cyc(2);
        ld = 1'b1;
        ren_n = 1'b1;
        cyc(4);
        chk("off_count", 18'(i_ffo_sink.got.size()), 18'h00002);
        chk("off_empty", i_ffo_sink.got[0], e);
        chk("off_full", i_ffo_sink.got[1], f);
        chk("off_tag", 18'(i_ffo_sink.tag[0] & i_ffo_sink.tag[1]), 18'h00001);
    endtask
    task automatic par_wr(input logic [17:0] e, input logic [17:0] f);
        ld = 1'b0;
        wen_n = 1'b0;
        din = e;
        cyc(1);
        din = f;
        cyc(1);
        ld = 1'b1;
        wen_n = 1'b1;
        cyc(1);
    endtask
    // one write per three cycles; the word past capacity must be refused
    task automatic fill(input int cap, input bit ft, input int n, input int m);
        for (int c = 1; c <= cap + 1; c++) begin
            wen_n = 1'b0;
            din = 18'(c);
            cyc(1);
            wen_n = 1'b1;
            cyc(2);
            flags((c > cap) ? cap : c, ft, n, m);
        end
    endtask
    task automatic drain(input int cnt, input bit ft);
        int w;
        w = 0;
        i_ffo_sink.got.delete();
        i_ffo_sink.tag.delete();
        stall = 1'b0;
        ren_n = ft;
        while (i_ffo_sink.got.size() < cnt && w < 3 * cnt + 20) begin
            cyc(1);
            w++;
        end
        ren_n = 1'b1;
        cyc(3);
        chk("drained", 18'(i_ffo_sink.got.size()), 18'(cnt));
        for (int i = 0; i < cnt; i++) chk("word", i_ffo_sink.got[i], 18'(i + 1));
        chk("word_tag", 18'(i_ffo_sink.tag[0] | i_ffo_sink.tag[cnt - 1]), 18'h00000);
    endtask
    // serial load of {full, empty}, lsb first, paused once with a memory write
    // both pause forms are used: load low first, then serial enable low
    task automatic ser(input logic [SB-1:0] bits, input int pause_at);
        i_ffo_sink.got.delete();
        for (int i = 0; i < SB; i++) begin
            if (i == pause_at) begin
                ld = 1'b0;
                sen_n = 1'b1;
                cyc(2);
                chk("pae_inval", ae_n, 1'b1);
                chk("paf_inval", af_n, 1'b1);
                ld = 1'b1;
                wen_n = 1'b0;
                din = 18'h0002A;
                cyc(1);
                wen_n = 1'b1;
                sen_n = 1'b0;
                cyc(4);
                chk("mid_word", i_ffo_sink.got[0], 18'h0002A);
            end
            ld = 1'b0;
            sen_n = 1'b0;
            si = bits[i];
            cyc(1);
        end
        ld = 1'b1;
        sen_n = 1'b1;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        cyc(8);
        rst = 1'b0;
        ld = 1'b1;
        cyc(2);
        chk("ser_mode", ser_m, 1'b0);
        chk("ft_mode", ft_m, 1'b0);
        flags(0, 0, DP, DP);
        rd_off(DP, DP);
        par_wr(18'h00004, 18'h00006);
        rd_off(18'h00004, 18'h00006);
        fill(D, 0, 4, 6);
        stall = 1'b1;
        ren_n = 1'b0;
        cyc(6);
        ren_n = 1'b1;
        chk("buf_valid", q_valid, 1'b1);
        flags(D, 0, 4, 6);
        drain(D, 0);
        flags(0, 0, 4, 6);
        fts = 1'b1;
        mrst_n = 1'b0;
        cyc(3);
        mrst_n = 1'b1;
        cyc(2);
        chk("ser_mode", ser_m, 1'b1);
        chk("ft_mode", ft_m, 1'b1);
        rd_off(DS, DS);
        ser({10'h005, 10'h003}, 5);
        cyc(4);
        flags(0, 1, 3, 5);
        par_wr(18'h00001, 18'h00001);
        rd_off(18'h00003, 18'h00005);
        stall = 1'b1;
        fill(D + 1, 1, 3, 5);
        drain(D + 1, 1);
        flags(0, 1, 3, 5);
        end_sim();
    end
    // watchdog, far beyond the expected run of some eight thousand cycles
    initial begin
        repeat (30000) @(posedge sys_clk);
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
